// ==== include/mcl_pkg.sv ====
// Constants for the modem-control side-band block
package mcl_pkg;

  // Clock and timing
  localparam int CLK_HZ = 40_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CNT_W = 28;
  localparam int RI_ON_MS = 1000;
  localparam int RI_PERIOD_MS = 5000;
  localparam int WAKE_MS = 20;
  localparam logic [CNT_W-1:0] RI_ON_CYC_D = CNT_W'(RI_ON_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] RI_PERIOD_CYC_D =
    CNT_W'(RI_PERIOD_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] WAKE_CYC_D = CNT_W'(WAKE_MS * CYC_PER_MS);

  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] MODE_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] EVENT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0C;

  // Control register fields
  localparam int CTRL_DSR_FOLLOW = 0;
  localparam int CTRL_DCD_FOLLOW = 1;
  localparam int CTRL_MSG_RING = 2;
  localparam int CTRL_EXT_RING = 3;
  localparam int CTRL_DTR_DROP = 4;
  localparam int CTRL_PSV_LSB = 5;
  localparam int PSV_W = 3;
  localparam logic [7:0] CTRL_RST = 8'h13;
  localparam logic [PSV_W-1:0] PSV_DTR_CTRL = 3'h3;

  // Mode register fields
  localparam int MODE_OP_LSB = 0;
  localparam int MODE_CARRIER = 4;
  localparam int MODE_VOICE_UP = 5;
  localparam int MODE_INPUT_PROMPT = 6;
  localparam int MODE_MSG_PENDING = 7;
  localparam logic [7:0] MODE_RST = 8'h00;

  typedef enum logic [1:0] {
    MCL_OP_COMMAND = 2'h0,
    MCL_OP_ONLINE_CMD = 2'h1,
    MCL_OP_DATA = 2'h2
  } mcl_op_t;

  // Event register bits (write one to fire)
  localparam int EVT_RING_START = 0;
  localparam int EVT_CALL_ANSWER = 1;
  localparam int EVT_MSG_ARRIVAL = 2;
  localparam int EVT_URC = 3;

  // Status register fields
  localparam int ST_DTR_ON = 0;
  localparam int ST_UART_EN = 1;
  localparam int ST_RX_READY = 2;
  localparam int ST_LP_IDLE = 3;
  localparam int ST_DSR_ON = 4;
  localparam int ST_DCD_ON = 5;
  localparam int ST_RI_ON = 6;
  localparam int ST_OK_PEND = 7;
  localparam int ST_PS_LSB = 8;

  // Power-saving wake sequence, Gray coded
  typedef enum logic [1:0] {
    MCL_PS_OFF = 2'b00,
    MCL_PS_WAKE = 2'b01,
    MCL_PS_ON = 2'b11
  } mcl_ps_t;

endpackage : mcl_pkg

// ==== rtl/mcl_modem_lines.sv ====
// Modem-control side-band lines with an AHB-Lite register slave
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module mcl_modem_lines
  import mcl_pkg::*;
#(
  parameter logic [CNT_W-1:0] RI_ON_CYC = RI_ON_CYC_D,
  parameter logic [CNT_W-1:0] RI_PERIOD_CYC = RI_PERIOD_CYC_D,
  parameter logic [CNT_W-1:0] WAKE_CYC = WAKE_CYC_D
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [ADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic dtr_n_i,
  input wire logic link_data_i,
  input wire logic busy_i,
  output logic dtr_pullup_en_o,
  output logic dsr_n_o,
  output logic dcd_n_o,
  output logic ri_n_o,
  output logic uart_en_o,
  output logic rx_ready_o,
  output logic lp_idle_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: address phase capture
  logic wr_pend_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic [7:0] ctrl_r;
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic ok_pend_r;

  wire addr_ph = hsel_i & htrans_i[1] & hready_i;
  wire wr_ph = addr_ph & hwrite_i & (hsize_i == 3'h2);
  wire rd_ph = addr_ph & ~hwrite_i;
  wire wr_ctrl = wr_pend_r & (wr_addr_r == CTRL_OFS);
  wire wr_mode = wr_pend_r & (wr_addr_r == MODE_OFS);
  wire wr_evt = wr_pend_r & (wr_addr_r == EVENT_OFS);
  wire wr_stat = wr_pend_r & (wr_addr_r == STATUS_OFS);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hreadyout_r <= 1'b0;
    end else begin
      wr_pend_r <= wr_ph;
      wr_addr_r <= haddr_i;
      hreadyout_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration fields
  wire dsr_follow = ctrl_r[CTRL_DSR_FOLLOW];
  wire dcd_follow = ctrl_r[CTRL_DCD_FOLLOW];
  wire msg_ring_en = ctrl_r[CTRL_MSG_RING];
  wire ext_ring_en = ctrl_r[CTRL_EXT_RING];
  wire dtr_drop_en = ctrl_r[CTRL_DTR_DROP];
  wire [PSV_W-1:0] psv = ctrl_r[CTRL_PSV_LSB +: PSV_W];
  wire dtr_ps_mode = (psv == PSV_DTR_CTRL);

  wire [1:0] op_mode = mode_r[MODE_OP_LSB +: 2];
  wire in_data = (op_mode == MCL_OP_DATA);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= hwdata_i[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // DTR sampling and edges
  logic dtr_r;
  logic dtr_prev_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dtr_r <= 1'b1;
      dtr_prev_r <= 1'b1;
    end else begin
      dtr_r <= dtr_n_i;
      dtr_prev_r <= dtr_r;
    end
  end

  wire dtr_on = ~dtr_r;
  wire dtr_rise_on = dtr_prev_r & ~dtr_r;
  wire dtr_fall_off = ~dtr_prev_r & dtr_r;

  //////////////////////////////////////////////////////////////////////////////
  // Operating mode; DTR drop forces online command
  wire dtr_drop_hit = dtr_fall_off & dtr_drop_en & in_data;

  always_comb begin
    mode_nxt = mode_r;
    if (wr_mode) begin
      mode_nxt = hwdata_i[7:0];
    end
    if (dtr_drop_hit) begin
      mode_nxt[MODE_OP_LSB +: 2] = MCL_OP_ONLINE_CMD;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r <= MODE_RST;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // OK result owed to software; set wins over a write-one clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ok_pend_r <= 1'b0;
    end else if (dtr_drop_hit) begin
      ok_pend_r <= 1'b1;
    end else if (wr_stat & hwdata_i[ST_OK_PEND]) begin
      ok_pend_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power-saving wake sequence
  mcl_ps_t ps_r;
  mcl_ps_t ps_nxt;
  logic [CNT_W-1:0] wake_cnt_r;

  always_comb begin
    ps_nxt = ps_r;
    case (ps_r)
      MCL_PS_OFF: begin
        if (!dtr_ps_mode) begin
          ps_nxt = MCL_PS_ON;
        end else if (dtr_rise_on) begin
          ps_nxt = MCL_PS_WAKE;
        end
      end
      MCL_PS_WAKE: begin
        if (!dtr_ps_mode) begin
          ps_nxt = MCL_PS_ON;
        end else if (!dtr_on) begin
          ps_nxt = MCL_PS_OFF;
        end else if (wake_cnt_r >= WAKE_CYC - 1'b1) begin
          ps_nxt = MCL_PS_ON;
        end
      end
      MCL_PS_ON: begin
        if (dtr_ps_mode && !dtr_on) begin
          ps_nxt = MCL_PS_OFF;
        end
      end
      default: begin
        ps_nxt = MCL_PS_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ps_r <= MCL_PS_ON;
      wake_cnt_r <= '0;
    end else begin
      ps_r <= ps_nxt;
      wake_cnt_r <= (ps_r == MCL_PS_WAKE) ? wake_cnt_r + 1'b1 : '0;
    end
  end

  wire uart_en = (ps_r != MCL_PS_OFF);
  wire rx_ready = (ps_r == MCL_PS_ON);
  wire lp_idle = dtr_ps_mode & (ps_r == MCL_PS_OFF)
    & ~dtr_on & ~busy_i;

  //////////////////////////////////////////////////////////////////////////////
  // Ring indication
  logic ring_act_r;
  logic [CNT_W-1:0] ring_cnt_r;
  logic [CNT_W-1:0] pulse_cnt_r;

  wire evt_ring = wr_evt & hwdata_i[EVT_RING_START];
  wire evt_answer = wr_evt & hwdata_i[EVT_CALL_ANSWER];
  wire evt_msg = wr_evt & hwdata_i[EVT_MSG_ARRIVAL];
  wire evt_urc = wr_evt & hwdata_i[EVT_URC];
  wire pulse_trig = (evt_msg & msg_ring_en)
    | ((evt_urc | link_data_i) & ext_ring_en);
  wire ring_wrap = (ring_cnt_r == RI_PERIOD_CYC - 1'b1);

  // Call ring cadence runs on its own counter, never on ring text
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ring_act_r <= 1'b0;
      ring_cnt_r <= '0;
    end else if (evt_ring) begin
      ring_act_r <= 1'b1;
      ring_cnt_r <= '0;
    end else if (evt_answer) begin
      ring_act_r <= 1'b0;
      ring_cnt_r <= '0;
    end else if (ring_act_r) begin
      ring_cnt_r <= ring_wrap ? '0 : ring_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_cnt_r <= '0;
    end else if (pulse_trig) begin
      pulse_cnt_r <= RI_ON_CYC;
    end else if (pulse_cnt_r != '0) begin
      pulse_cnt_r <= pulse_cnt_r - 1'b1;
    end
  end

  // Call cadence and event pulses merge onto the one RI line
  wire ring_on = ring_act_r & (ring_cnt_r < RI_ON_CYC);
  wire ri_on = ring_on | (pulse_cnt_r != '0);

  //////////////////////////////////////////////////////////////////////////////
  // DSR and DCD
  wire dsr_on = dsr_follow ? in_data : 1'b1;
  wire dcd_cause = mode_r[MODE_CARRIER]
    | mode_r[MODE_VOICE_UP]
    | in_data
    | mode_r[MODE_INPUT_PROMPT]
    | mode_r[MODE_MSG_PENDING];
  wire dcd_on = dcd_follow ? dcd_cause : 1'b1;

  // Line drivers; DSR, DCD and RI low when ON and OFF through reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dsr_n_o <= 1'b1;
      dcd_n_o <= 1'b1;
      ri_n_o <= 1'b1;
      dtr_pullup_en_o <= 1'b1;
      uart_en_o <= 1'b1;
      rx_ready_o <= 1'b1;
      lp_idle_o <= 1'b0;
    end else begin
      dsr_n_o <= ~dsr_on;
      dcd_n_o <= ~dcd_on;
      ri_n_o <= ~ri_on;
      dtr_pullup_en_o <= 1'b1;
      uart_en_o <= uart_en;
      rx_ready_o <= rx_ready;
      lp_idle_o <= lp_idle;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path
  // Status word built field by field
  logic [31:0] status_w;

  always_comb begin
    status_w = 32'h0000_0000;
    status_w[ST_DTR_ON] = dtr_on;
    status_w[ST_UART_EN] = uart_en;
    status_w[ST_RX_READY] = rx_ready;
    status_w[ST_LP_IDLE] = lp_idle;
    status_w[ST_DSR_ON] = dsr_on;
    status_w[ST_DCD_ON] = dcd_on;
    status_w[ST_RI_ON] = ri_on;
    status_w[ST_OK_PEND] = ok_pend_r;
    status_w[ST_PS_LSB +: 2] = ps_r;
  end

  wire sel_ctrl = (haddr_i == CTRL_OFS);
  wire sel_mode = (haddr_i == MODE_OFS);
  wire sel_stat = (haddr_i == STATUS_OFS);
  logic [31:0] rd_mux;

  always_comb begin
    if (sel_ctrl) begin
      rd_mux = {24'h0, ctrl_r};
    end else if (sel_mode) begin
      rd_mux = {24'h0, mode_r};
    end else if (sel_stat) begin
      rd_mux = status_w;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_r <= '0;
    end else if (rd_ph) begin
      hrdata_r <= rd_mux;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
    end
  end

  assign hrdata_o = hrdata_r;
  assign hreadyout_o = hreadyout_r;

endmodule : mcl_modem_lines

// ==== verif/mcl_lines_sva.sv ====
// Checker for the modem-control side-band lines
`timescale 1ns/1ps
module mcl_lines_sva
  import mcl_pkg::*;
#(
  parameter logic [CNT_W-1:0] WAKE_CYC = WAKE_CYC_D
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hresp_o,
  input wire logic dtr_n_i,
  input wire logic dtr_pullup_en_o,
  input wire logic dsr_n_o,
  input wire logic dcd_n_o,
  input wire logic ri_n_o,
  input wire logic uart_en_o,
  input wire logic rx_ready_o,
  input wire logic lp_idle_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [CNT_W-1:0] wait_r;
  logic [CNT_W-1:0] wait_nxt;
  // Cycles spent enabled but not yet ready
  assign wait_nxt = (uart_en_o && !rx_ready_o) ? wait_r + 1'b1 : '0;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_r <= '0;
    end else begin
      wait_r <= wait_nxt;
    end
  end
  pullup_held_a: assert property (dtr_pullup_en_o)
    else $error("dtr pull-up not enabled");
  idle_port_off_a: assert property (lp_idle_o |-> !uart_en_o)
    else $error("idle while port enabled");
  dtr_on_enables_a: assert property ((!dtr_n_i)[*4] |-> uart_en_o)
    else $error("port disabled while dtr on");
  dtr_on_awake_a: assert property ((!dtr_n_i)[*4] |-> !lp_idle_o)
    else $error("idle while dtr on");
  ready_needs_port_a: assert property (rx_ready_o |-> uart_en_o)
    else $error("ready without port enabled");
  wake_time_a: assert property (
    $rose(rx_ready_o) |-> wait_r + 2 >= WAKE_CYC)
    else $error("ready before wake time");
  init_lines_off_a: assert property (
    $fell(rst_i) |=> dsr_n_o && dcd_n_o && ri_n_o)
    else $error("lines not off at init");
  bus_okay_a: assert property (!hresp_o)
    else $error("bus response not okay");
endmodule : mcl_lines_sva

bind mcl_modem_lines mcl_lines_sva #(.WAKE_CYC(WAKE_CYC)) u_sva (
  .clk_i, .rst_i, .hresp_o, .dtr_n_i, .dtr_pullup_en_o, .dsr_n_o,
  .dcd_n_o, .ri_n_o, .uart_en_o, .rx_ready_o, .lp_idle_o);

// ==== verif/mcl_dte_model.sv ====
// Host terminal model that owns the DTR line
`timescale 1ns/1ps
module mcl_dte_model (
  input wire logic clk_i,
  input wire logic drive_i,
  input wire logic on_i,
  output logic dtr_n_o,
  output logic tx_ok_o
);
  logic [7:0] on_cnt_r;
  // Released line sits at the pull-up level
  assign dtr_n_o = drive_i ? !on_i : 1'b1;
  always_ff @(posedge clk_i) begin
    if (!(drive_i && on_i)) begin
      on_cnt_r <= 8'h00;
    end else if (on_cnt_r != 8'hFF) begin
      on_cnt_r <= on_cnt_r + 8'h01;
    end
  end
  // Characters only after DTR has been ON for 20 cycles
  assign tx_ok_o = on_cnt_r >= 8'h14;
endmodule : mcl_dte_model

// ==== verif/tb_mcl_modem_lines.sv ====
// Testbench for the modem-control side-band lines
`timescale 1ns/1ps
module tb_mcl_modem_lines
  import mcl_pkg::*;
;
  logic clk_i, rst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, link_data_i;
  logic [7:0] haddr_i;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic [31:0] hwdata_i, hrdata_o, d;
  logic busy_i, dtr_pullup_en_o, dsr_n_o, dcd_n_o, ri_n_o, uart_en_o;
  logic rx_ready_o, lp_idle_o, dtr_n, dte_drive, dte_on, tx_ok;
  int compares, bad_count, cycles;
  localparam logic [7:0] MV [7] =
    '{8'h02, 8'h01, 8'h11, 8'h20, 8'h40, 8'h80, 8'h00};
  localparam logic [1:0] EV [7] =
    '{2'h0, 2'h3, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3};

  mcl_modem_lines #(.RI_ON_CYC(28'hA), .RI_PERIOD_CYC(28'h32),
    .WAKE_CYC(28'h8)) u_dut (
    .clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
    .dtr_n_i(dtr_n), .link_data_i, .busy_i, .dtr_pullup_en_o, .dsr_n_o,
    .dcd_n_o, .ri_n_o, .uart_en_o, .rx_ready_o, .lp_idle_o);
  mcl_dte_model u_dte (.clk_i, .drive_i(dte_drive), .on_i(dte_on),
    .dtr_n_o(dtr_n), .tx_ok_o(tx_ok));

  task automatic chk(input string n, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    d = hrdata_o;
  endtask : xfer
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string n);
    xfer(1'b0, a, 32'h0);
    chk(n, d, e);
  endtask : rdc

  task automatic t_init();
    chk("ri", 32'(ri_n_o), 32'h1);
    chk("pullup", 32'(dtr_pullup_en_o), 32'h1);
    xfer(1'b1, 8'h10, 32'hFF);
    rdc(8'h10, 32'h0, "unmapped");
    rdc(CTRL_OFS, {24'h0, CTRL_RST}, "ctrl");
    rdc(EVENT_OFS, 32'h0, "event read");
    $display("TEST init done");
  endtask : t_init
  task automatic t_modes();
    for (int i = 0; i < 7; i++) begin
      xfer(1'b1, MODE_OFS, {24'h0, MV[i]});
      cyc(3);
      chk("dsr", 32'(dsr_n_o), 32'(EV[i][1]));
      chk("dcd", 32'(dcd_n_o), 32'(EV[i][0]));
    end
    xfer(1'b1, CTRL_OFS, 32'h10);
    cyc(3);
    chk("always on", {30'h0, dsr_n_o, dcd_n_o}, 32'h0);
    xfer(1'b1, CTRL_OFS, 32'h13);
    $display("TEST modes done");
  endtask : t_modes
  task automatic t_ring();
    xfer(1'b1, EVENT_OFS, 32'h1);
    cyc(3);
    chk("ring on", 32'(ri_n_o), 32'h0);
    cyc(10);
    chk("ring gap", 32'(ri_n_o), 32'h1);
    cyc(40);
    chk("ring again", 32'(ri_n_o), 32'h0);
    xfer(1'b1, EVENT_OFS, 32'h2);
    cyc(2);
    chk("answered", 32'(ri_n_o), 32'h1);
    cyc(50);
    chk("ring stopped", 32'(ri_n_o), 32'h1);
    $display("TEST ring done");
  endtask : t_ring
  task automatic t_msg();
    xfer(1'b1, EVENT_OFS, 32'h4);
    cyc(3);
    chk("msg masked", 32'(ri_n_o), 32'h1);
    xfer(1'b1, CTRL_OFS, 32'h17);
    xfer(1'b1, EVENT_OFS, 32'h4);
    cyc(5);
    xfer(1'b1, EVENT_OFS, 32'h4);
    cyc(6);
    chk("msg retrigger", 32'(ri_n_o), 32'h0);
    cyc(10);
    chk("msg end", 32'(ri_n_o), 32'h1);
    xfer(1'b1, CTRL_OFS, 32'h1B);
    @(posedge clk_i);
    link_data_i <= 1'b1;
    @(posedge clk_i);
    link_data_i <= 1'b0;
    cyc(3);
    chk("link ring", 32'(ri_n_o), 32'h0);
    cyc(12);
    xfer(1'b1, EVENT_OFS, 32'h8);
    cyc(3);
    chk("urc ring", 32'(ri_n_o), 32'h0);
    $display("TEST msg done");
  endtask : t_msg
  task automatic t_power();
    xfer(1'b1, CTRL_OFS, 32'h73);
    cyc(6);
    chk("port off idle", {30'h0, uart_en_o, lp_idle_o}, 32'h1);
    @(posedge clk_i);
    busy_i <= 1'b1;
    cyc(4);
    chk("busy", 32'(lp_idle_o), 32'h0);
    @(posedge clk_i);
    busy_i <= 1'b0;
    dte_drive <= 1'b1;
    dte_on <= 1'b1;
    cyc(3);
    chk("waking", {30'h0, uart_en_o, rx_ready_o}, 32'h2);
    for (int i = 0; i < 100 && tx_ok !== 1'b1; i++) @(posedge clk_i);
    #1;
    chk("awake", {30'h0, rx_ready_o, lp_idle_o}, 32'h2);
    xfer(1'b1, MODE_OFS, 32'h02);
    dte_on <= 1'b0;
    cyc(6);
    rdc(MODE_OFS, 32'h01, "dtr drop mode");
    xfer(1'b0, STATUS_OFS, 32'h0);
    chk("ok pending", 32'(d[ST_OK_PEND]), 32'h1);
    xfer(1'b1, STATUS_OFS, 32'h1 << ST_OK_PEND);
    xfer(1'b0, STATUS_OFS, 32'h0);
    chk("ok cleared", 32'(d[ST_OK_PEND]), 32'h0);
    chk("port off", {30'h0, uart_en_o, dsr_n_o}, 32'h1);
    $display("TEST power done");
  endtask : t_power

  task automatic end_of_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    {rst_i, hsel_i, hwrite_i, link_data_i, busy_i} = 5'h10;
    {dte_drive, dte_on, haddr_i, htrans_i} = 12'h0;
    hsize_i = 3'h2;
    hwdata_i = 32'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc(2);
    t_init();
    t_modes();
    t_ring();
    t_msg();
    t_power();
    end_of_test();
  end
endmodule : tb_mcl_modem_lines
